/* File: common/charger_regs_pkg.sv */
// constants for the input-limit and measurement register bank
package charger_regs_pkg;

	// bus geometry
	localparam int ADDR_WIDTH  = 8;
	localparam int DATA_WIDTH  = 32;
	localparam int STRB_WIDTH  = 4;
	localparam int BYTE_WIDTH  = 8;
	localparam int CODE_WIDTH  = 7;
	localparam int INDEX_WIDTH = 6;
	localparam int WORD_SHIFT  = 2;

	// register indexes, byte address is index times four
	localparam logic [INDEX_WIDTH-1:0] IDX_LIMIT   = 6'h0D;
	localparam logic [INDEX_WIDTH-1:0] IDX_BATTERY = 6'h0E;
	localparam logic [INDEX_WIDTH-1:0] IDX_SYSTEM  = 6'h0F;
	localparam logic [INDEX_WIDTH-1:0] IDX_THERM   = 6'h10;
	localparam logic [INDEX_WIDTH-1:0] IDX_STATUS  = 6'h20;
	localparam logic [INDEX_WIDTH-1:0] IDX_MASK    = 6'h21;
	localparam logic [WORD_SHIFT-1:0]  WORD_ALIGN  = 2'h0;

	// field positions
	localparam int METHOD_BIT = 7;
	localparam int FLAG_BIT   = 7;
	localparam int STRB_LANE  = 0;

	// reset and clamp values
	localparam logic                  METHOD_RESET     = 1'h0;
	localparam logic [CODE_WIDTH-1:0] LIMIT_RESET_CODE = 7'h12;
	localparam logic [CODE_WIDTH-1:0] LIMIT_FLOOR_CODE = 7'h0D;
	localparam logic [CODE_WIDTH-1:0] CODE_RESET       = 7'h00;
	localparam logic [DATA_WIDTH-1:0] DATA_ZERO        = 32'h0000_0000;

	// code scaling, for reference by software and bench
	localparam int LIMIT_OFFSET_MV   = 2600;
	localparam int LIMIT_STEP_MV     = 100;
	localparam int RAIL_OFFSET_MV    = 2304;
	localparam int RAIL_STEP_MV      = 20;
	localparam int THERM_OFFSET_MPCT = 21000;
	localparam int THERM_STEP_MPCT   = 465;

	// interrupt events
	localparam int EVENT_COUNT     = 4;
	localparam int EV_THERM_ENTER  = 0;
	localparam int EV_THERM_EXIT   = 1;
	localparam int EV_ADC_UPDATE   = 2;
	localparam int EV_LIMIT_UPDATE = 3;
	localparam logic [EVENT_COUNT-1:0] EVENTS_CLEAR = 4'h0;

endpackage

/* File: src/level_sync.sv */
// two-stage synchroniser with edge detection for pin levels
`timescale 1ns/1ps
module level_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             arst_n,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut,
	output logic      [WIDTH-1:0] rose,
	output logic      [WIDTH-1:0] fell
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] stable_q;
	logic [WIDTH-1:0] last_q;

	// first stage feeds only the second
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_q   <= '0;
			stable_q <= '0;
			last_q   <= '0;
		end else begin
			meta_q   <= asyncIn;
			stable_q <= meta_q;
			last_q   <= stable_q;
		end
	end

	assign syncOut = stable_q;
	assign rose    = stable_q & ~last_q;
	assign fell    = ~stable_q & last_q;
endmodule

/* File: src/charger_vin_limit_and_adc_regs.sv */
// input voltage limit control and measurement readout registers on apb
`timescale 1ns/1ps

// How it works
// - bit 7 of limit register picks relative (0, reset) or absolute (1) method.
// - limit code is 2.6 V plus 100 mV per count, reset code 0010010.
// - applied limit codes below 0001101 are raised to 0001101.
// - relative mode: host writes limit field only with bit 7 set; internal control loads it.
// - absolute mode: host reads and writes limit field, device applies it.
// - battery register bit 7 shows thermal regulation, read only.
// - battery register low bits hold battery voltage code, reset zero.
// - system register low bits hold system voltage code, reset zero.
// - thermistor register low bits hold thermistor ratio code, reset zero.
// - bit 7 of system and thermistor registers always reads zero.
module charger_vin_limit_and_adc_regs
	import charger_regs_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  arst_n,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [ADDR_WIDTH-1:0] paddr,
	input  wire logic [DATA_WIDTH-1:0] pwdata,
	input  wire logic [STRB_WIDTH-1:0] pstrb,
	output logic      [DATA_WIDTH-1:0] prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  thermalRegulationPin,
	input  wire logic                  adcSampleValid,
	input  wire logic [CODE_WIDTH-1:0] batteryVoltageIn,
	input  wire logic [CODE_WIDTH-1:0] systemVoltageIn,
	input  wire logic [CODE_WIDTH-1:0] thermistorRatioIn,
	input  wire logic                  relativeLimitValid,
	input  wire logic [CODE_WIDTH-1:0] relativeLimitIn,
	output logic      [CODE_WIDTH-1:0] appliedLimitCode,
	output logic                       limitMethodAbsolute,
	output logic                       interruptReq
);

	// address decode helper, used for every register
	function automatic logic hitReg(
		input logic [ADDR_WIDTH-1:0]  addr,
		input logic [INDEX_WIDTH-1:0] idx
	);
		hitReg = (addr[ADDR_WIDTH-1:WORD_SHIFT] == idx)
			&& (addr[WORD_SHIFT-1:0] == WORD_ALIGN);
	endfunction

	// floor clamp on the applied limit code
	function automatic logic [CODE_WIDTH-1:0] clampLimit(
		input logic [CODE_WIDTH-1:0] code
	);
		clampLimit = (code < LIMIT_FLOOR_CODE) ? LIMIT_FLOOR_CODE : code;
	endfunction

	// register state
	logic                   vinLimitMethodSelect_q;
	logic                   vinLimitMethodSelect_d;
	logic [CODE_WIDTH-1:0]  inputVoltageLimit_q;
	logic [CODE_WIDTH-1:0]  inputVoltageLimit_d;
	logic [CODE_WIDTH-1:0]  batteryVoltageCode_q;
	logic [CODE_WIDTH-1:0]  systemVoltageCode_q;
	logic [CODE_WIDTH-1:0]  thermistorRatioCode_q;
	logic [EVENT_COUNT-1:0] eventStatus_q;
	logic [EVENT_COUNT-1:0] eventStatus_d;
	logic [EVENT_COUNT-1:0] eventMask_q;
	logic [EVENT_COUNT-1:0] eventMask_d;

	// bus response registers
	logic                  pready_q;
	logic                  pslverr_q;
	logic [DATA_WIDTH-1:0] prdata_q;
	logic [DATA_WIDTH-1:0] prdata_d;

	// output registers
	logic [CODE_WIDTH-1:0] appliedLimit_q;
	logic [CODE_WIDTH-1:0] appliedLimit_d;
	logic                  methodOut_q;
	logic                  interrupt_q;
	logic                  interrupt_d;

	// synchronised thermal pin
	logic thermalRegulationFlag;
	logic thermalRose;
	logic thermalFell;

	level_sync #(
		.WIDTH (1)
	) thermalSync (
		.clk     (clk),
		.arst_n  (arst_n),
		.asyncIn (thermalRegulationPin),
		.syncOut (thermalRegulationFlag),
		.rose    (thermalRose),
		.fell    (thermalFell)
	);

	// transfer phases
	wire setupPhase  = psel && !penable;
	wire accessEnd   = psel && penable && pready_q;
	wire writeCommit = accessEnd && pwrite && pstrb[STRB_LANE];

	// register hits
	wire hitLimit   = hitReg(paddr, IDX_LIMIT);
	wire hitBattery = hitReg(paddr, IDX_BATTERY);
	wire hitSystem  = hitReg(paddr, IDX_SYSTEM);
	wire hitTherm   = hitReg(paddr, IDX_THERM);
	wire hitStatus  = hitReg(paddr, IDX_STATUS);
	wire hitMask    = hitReg(paddr, IDX_MASK);
	wire hitAny     = hitLimit || hitBattery || hitSystem
		|| hitTherm || hitStatus || hitMask;

	// write data fields
	wire                  wrMethod = pwdata[METHOD_BIT];
	wire [CODE_WIDTH-1:0] wrCode   = pwdata[CODE_WIDTH-1:0];
	wire [EVENT_COUNT-1:0] wrBits  = pwdata[EVENT_COUNT-1:0];

	// host write strobes per register
	wire limitWrite  = writeCommit && hitLimit;
	wire statusWrite = writeCommit && hitStatus;
	wire maskWrite   = writeCommit && hitMask;

	// limit field is host writable only when the write selects absolute mode
	wire hostCodeWrite = limitWrite && wrMethod;

	// internal control only owns the field in relative mode
	wire internalCodeLoad = relativeLimitValid && !vinLimitMethodSelect_q;

	// method select bit
	assign vinLimitMethodSelect_d = limitWrite ? wrMethod
		: vinLimitMethodSelect_q;

	// host write that sets the method bit beats a same-cycle internal load;
	// a host write with bit 7 clear does not touch the field at all
	assign inputVoltageLimit_d = hostCodeWrite ? wrCode
		: internalCodeLoad ? relativeLimitIn
		: inputVoltageLimit_q;

	// stored code is kept as written; the clamp acts on the applied value
	assign appliedLimit_d = clampLimit(inputVoltageLimit_d);

	// events raised by this block
	logic [EVENT_COUNT-1:0] eventSet;
	logic limitChanged;

	assign limitChanged = inputVoltageLimit_d != inputVoltageLimit_q;

	always_comb begin
		eventSet                  = EVENTS_CLEAR;
		eventSet[EV_THERM_ENTER]  = thermalRose;
		eventSet[EV_THERM_EXIT]   = thermalFell;
		eventSet[EV_ADC_UPDATE]   = adcSampleValid;
		eventSet[EV_LIMIT_UPDATE] = internalCodeLoad && limitChanged;
	end

	// write one to clear, a set in the same cycle wins
	wire [EVENT_COUNT-1:0] statusClear = statusWrite ? wrBits : EVENTS_CLEAR;

	assign eventStatus_d = (eventStatus_q & ~statusClear) | eventSet;
	assign eventMask_d   = maskWrite ? wrBits : eventMask_q;
	assign interrupt_d   = |(eventStatus_d & eventMask_d);

	// read data words
	wire [DATA_WIDTH-1:0] limitWord = {
		{(DATA_WIDTH-BYTE_WIDTH){1'b0}},
		vinLimitMethodSelect_q,
		inputVoltageLimit_q
	};

	wire [DATA_WIDTH-1:0] batteryWord = {
		{(DATA_WIDTH-BYTE_WIDTH){1'b0}},
		thermalRegulationFlag,
		batteryVoltageCode_q
	};

	wire [DATA_WIDTH-1:0] systemWord = {
		{(DATA_WIDTH-BYTE_WIDTH){1'b0}},
		1'b0,
		systemVoltageCode_q
	};

	wire [DATA_WIDTH-1:0] thermWord = {
		{(DATA_WIDTH-BYTE_WIDTH){1'b0}},
		1'b0,
		thermistorRatioCode_q
	};

	wire [DATA_WIDTH-1:0] statusWord = {
		{(DATA_WIDTH-EVENT_COUNT){1'b0}},
		eventStatus_q
	};

	wire [DATA_WIDTH-1:0] maskWord = {
		{(DATA_WIDTH-EVENT_COUNT){1'b0}},
		eventMask_q
	};

	// read selection, unmapped reads as zero
	wire [DATA_WIDTH-1:0] readWord =
		hitLimit   ? limitWord :
		hitBattery ? batteryWord :
		hitSystem  ? systemWord :
		hitTherm   ? thermWord :
		hitStatus  ? statusWord :
		hitMask    ? maskWord :
		DATA_ZERO;

	// read data captured in setup, so access lasts exactly one cycle
	assign prdata_d = (setupPhase && !pwrite) ? readWord : DATA_ZERO;

	// apb response: no wait states, all outputs registered
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= DATA_ZERO;
		end else if (setupPhase) begin
			pready_q  <= 1'b1;
			pslverr_q <= !hitAny;
			prdata_q  <= prdata_d;
		end else if (accessEnd) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= DATA_ZERO;
		end
	end

	// limit register, reset to relative method and default code
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			vinLimitMethodSelect_q <= METHOD_RESET;
			inputVoltageLimit_q    <= LIMIT_RESET_CODE;
		end else begin
			vinLimitMethodSelect_q <= vinLimitMethodSelect_d;
			inputVoltageLimit_q    <= inputVoltageLimit_d;
		end
	end

	// measurement codes, loaded together so a read sees one sample
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			batteryVoltageCode_q  <= CODE_RESET;
			systemVoltageCode_q   <= CODE_RESET;
			thermistorRatioCode_q <= CODE_RESET;
		end else if (adcSampleValid) begin
			batteryVoltageCode_q  <= batteryVoltageIn;
			systemVoltageCode_q   <= systemVoltageIn;
			thermistorRatioCode_q <= thermistorRatioIn;
		end
	end

	// interrupt status and mask
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			eventStatus_q <= EVENTS_CLEAR;
			eventMask_q   <= EVENTS_CLEAR;
		end else begin
			eventStatus_q <= eventStatus_d;
			eventMask_q   <= eventMask_d;
		end
	end

	// outputs straight from flops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			appliedLimit_q <= LIMIT_RESET_CODE;
			methodOut_q    <= METHOD_RESET;
			interrupt_q    <= 1'b0;
		end else begin
			appliedLimit_q <= appliedLimit_d;
			methodOut_q    <= vinLimitMethodSelect_d;
			interrupt_q    <= interrupt_d;
		end
	end

	assign prdata              = prdata_q;
	assign pready              = pready_q;
	assign pslverr             = pslverr_q;
	assign appliedLimitCode    = appliedLimit_q;
	assign limitMethodAbsolute = methodOut_q;
	assign interruptReq        = interrupt_q;

endmodule

/* File: dv/charger_regs_properties.sv */
// concurrent checks on the limit and reading register ports
`timescale 1ns/1ps
module charger_regs_properties
	import charger_regs_pkg::*;
(
	input wire logic                  clk,
	input wire logic                  arst_n,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [ADDR_WIDTH-1:0] paddr,
	input wire logic [DATA_WIDTH-1:0] pwdata,
	input wire logic [STRB_WIDTH-1:0] pstrb,
	input wire logic [DATA_WIDTH-1:0] prdata,
	input wire logic                  pready,
	input wire logic                  thermalRegulationPin,
	input wire logic                  relativeLimitValid,
	input wire logic [CODE_WIDTH-1:0] relativeLimitIn,
	input wire logic [CODE_WIDTH-1:0] appliedLimitCode,
	input wire logic                  limitMethodAbsolute
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	wire logic                  limitWr = psel && penable && pready && pwrite
		&& paddr == {IDX_LIMIT, WORD_ALIGN} && pstrb[STRB_LANE];
	wire logic [CODE_WIDTH-1:0] relClamp = relativeLimitIn < LIMIT_FLOOR_CODE
		? LIMIT_FLOOR_CODE : relativeLimitIn;
	wire logic [CODE_WIDTH-1:0] wrClamp = pwdata[6:0] < LIMIT_FLOOR_CODE
		? LIMIT_FLOOR_CODE : pwdata[6:0];
	// pin must outlast the two-flop synchroniser before the flag is trusted
	sequence hotFor4;
		thermalRegulationPin [*4];
	endsequence
	sequence batteryRead;
		psel && !penable && !pwrite && paddr == {IDX_BATTERY, WORD_ALIGN};
	endsequence
	chk_reset_limit: assert property ($rose(arst_n) |->
		appliedLimitCode == LIMIT_RESET_CODE && !limitMethodAbsolute)
		else $error("limit not at reset value");
	chk_floor_clamp: assert property (appliedLimitCode >= LIMIT_FLOOR_CODE)
		else $error("applied limit below floor");
	chk_relative_load: assert property (!limitMethodAbsolute && relativeLimitValid && !limitWr
		|=> appliedLimitCode == $past(relClamp))
		else $error("relative code not applied");
	chk_absolute_write: assert property (limitWr && pwdata[METHOD_BIT] |=>
		limitMethodAbsolute && appliedLimitCode == $past(wrClamp))
		else $error("absolute write not applied");
	chk_absolute_hold: assert property (limitMethodAbsolute && !limitWr |=> $stable(appliedLimitCode))
		else $error("absolute limit moved without write");
	chk_method_hold: assert property (!limitWr |=> $stable(limitMethodAbsolute))
		else $error("method bit moved without write");
	chk_thermal_flag: assert property (hotFor4 ##0 batteryRead |=> prdata[FLAG_BIT])
		else $error("thermal flag not read back");
	chk_reserved_zero: assert property (pready && !pwrite && (paddr == {IDX_SYSTEM, WORD_ALIGN}
		|| paddr == {IDX_THERM, WORD_ALIGN}) |-> !prdata[7])
		else $error("reserved bit read as one");
endmodule
bind charger_vin_limit_and_adc_regs charger_regs_properties props (.*);

/* File: dv/apb_host_model.sv */
// host software model issuing apb transfers to the register bank
`timescale 1ns/1ps
module apb_host_model
	import charger_regs_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  pready,
	output logic                       psel,
	output logic                       penable,
	output logic                       pwrite,
	output logic      [ADDR_WIDTH-1:0] paddr,
	output logic      [DATA_WIDTH-1:0] pwdata,
	output logic      [STRB_WIDTH-1:0] pstrb
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = DATA_ZERO;
		pstrb = 4'h0;
	end
	// limit code goes out with the method bit, a clear bit only probes refusal
	task automatic xfer(input logic w, input logic [ADDR_WIDTH-1:0] a, input logic [DATA_WIDTH-1:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= 4'hF;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
		// released lines show junk so stale values are never trusted
		paddr <= ~a;
		pwdata <= ~d;
		@(posedge clk);
	endtask
endmodule

/* File: dv/charger_vin_limit_and_adc_regs_test.sv */
// self-checking bench for the input limit and reading register bank
`timescale 1ns/1ps
module charger_vin_limit_and_adc_regs_test
	import charger_regs_pkg::*;
;
	localparam logic [7:0] A_LIM = {IDX_LIMIT, WORD_ALIGN};
	localparam logic [7:0] A_BAT = {IDX_BATTERY, WORD_ALIGN};
	localparam logic [7:0] A_SYS = {IDX_SYSTEM, WORD_ALIGN};
	localparam logic [7:0] A_TH  = {IDX_THERM, WORD_ALIGN};
	localparam logic [7:0] A_ST  = {IDX_STATUS, WORD_ALIGN};
	logic                  clk = 1'b0;
	logic                  arst_n = 1'b0;
	logic                  psel, penable, pwrite, pready, pslverr, interruptReq;
	logic                  thermalRegulationPin, adcSampleValid, relativeLimitValid;
	logic                  limitMethodAbsolute;
	logic [ADDR_WIDTH-1:0] paddr;
	logic [DATA_WIDTH-1:0] pwdata, prdata;
	logic [STRB_WIDTH-1:0] pstrb;
	logic [CODE_WIDTH-1:0] batteryVoltageIn, systemVoltageIn, thermistorRatioIn;
	logic [CODE_WIDTH-1:0] relativeLimitIn, appliedLimitCode;
	logic [DATA_WIDTH:0]   q[$];
	int                    fail_count = 0, total_checks = 0, cycles = 0;
	always #4 clk = ~clk;
	apb_host_model host (.*);
	charger_vin_limit_and_adc_regs DUT (.*);
	task automatic chk(string n, logic [DATA_WIDTH:0] e, logic [DATA_WIDTH:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	// method bit above the applied code, compared against the expected byte
	task automatic chk_limit(logic [7:0] e);
		chk("limit", {25'h0, e}, {25'h0, limitMethodAbsolute, appliedLimitCode});
	endtask
	task automatic chk_irq(logic e);
		chk("irq", {32'h0, e}, {32'h0, interruptReq});
	endtask
	task automatic rd(logic [ADDR_WIDTH-1:0] a, logic [DATA_WIDTH:0] e);
		q.push_back(e);
		host.xfer(1'b0, a, DATA_ZERO);
	endtask
	task automatic wr(logic [ADDR_WIDTH-1:0] a, logic [7:0] d);
		host.xfer(1'b1, a, {24'h00_0000, d});
	endtask
	task automatic pulse(logic adc);
		adcSampleValid <= adc;
		relativeLimitValid <= !adc;
		@(posedge clk);
		adcSampleValid <= 1'b0;
		relativeLimitValid <= 1'b0;
		@(posedge clk);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// read data plus error flag compared at the access edge, oldest note first
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			test_done();
		end else if (psel && penable && pready === 1'b1 && !pwrite)
			chk("read", q.pop_front(), {pslverr, prdata});
	end
	initial begin
		void'($urandom(64520));
		{thermalRegulationPin, adcSampleValid, relativeLimitValid} = 3'h0;
		{batteryVoltageIn, systemVoltageIn, thermistorRatioIn, relativeLimitIn} = 28'h000_0000;
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		rd(A_LIM, 33'h12); // limit reset code
		rd(A_BAT, 33'h0); // battery reset
		rd(A_SYS, 33'h0); // system reset
		rd(A_TH, 33'h0); // thermistor reset
		$display("test reset done");
		wr(A_LIM, 8'h05);
		rd(A_LIM, 33'h12); // code locked in relative mode
		relativeLimitIn <= 7'h08;
		pulse(1'b0);
		chk_limit(8'h0D); // floor
		rd(A_LIM, 33'h08); // raw code kept
		wr(A_LIM, 8'hB0);
		chk_limit(8'hB0); // absolute
		relativeLimitIn <= 7'h40;
		pulse(1'b0);
		rd(A_LIM, 33'hB0); // internal load ignored
		wr(A_LIM, 8'h85);
		chk_limit(8'h8D); // floor
		rd(A_LIM, 33'h85); // readback
		$display("test limit done");
		wr({IDX_MASK, WORD_ALIGN}, 8'h04);
		thermalRegulationPin <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			{batteryVoltageIn, systemVoltageIn, thermistorRatioIn} <= 21'($urandom);
			pulse(1'b1);
			chk_irq(1'b1);
			rd(A_BAT, {25'h0, 1'b1, batteryVoltageIn}); // flag and code
			rd(A_SYS, {26'h0, systemVoltageIn}); // code, top bit zero
			rd(A_TH, {26'h0, thermistorRatioIn}); // code, top bit zero
		end
		wr(A_SYS, 8'hFF);
		rd(A_SYS, {26'h0, systemVoltageIn}); // write ignored
		thermalRegulationPin <= 1'b0;
		repeat (3) @(posedge clk);
		rd(A_BAT, {26'h0, batteryVoltageIn}); // flag cleared
		rd(A_ST, 33'h0F);
		wr(A_ST, 8'h0F);
		chk_irq(1'b0);
		wr({IDX_MASK, WORD_ALIGN}, 8'h00);
		pulse(1'b1);
		chk_irq(1'b0);
		rd(A_ST, 33'h04);
		rd(8'h44, {1'b1, DATA_ZERO});
		$display("test readings done");
		arst_n <= 1'b0;
		@(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		rd(A_LIM, 33'h12); // reset drops absolute mode and code
		chk_limit(8'h12); // applied code back at default
		$display("test reset again done");
		test_done();
	end
endmodule
